// ---- rtl/slc_cfg_if.sv ----
// Configuration link between the link controller and the output device.
`timescale 1ns/1ps
interface slc_cfg_if;
  logic req;
  logic write;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;

  modport dev (
    input req,
    input write,
    input addr,
    input wdata,
    output rdata,
    output ack
  );

  modport ctl (
    output req,
    output write,
    output addr,
    output wdata,
    input rdata,
    input ack
  );
endinterface : slc_cfg_if

// ---- rtl/slc_controller.sv ----
// Link controller: APB slave that issues ordered configuration accesses.
`timescale 1ns/1ps
module slc_controller (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  slc_cfg_if.ctl cfg
);
  import slc_pkg::*;

  slc_ctl_state_e state;
  logic apb_write;
  logic apb_access;
  logic cmd_write;
  logic [11:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic cmd_ok;
  logic refused;
  logic link_shadow;
  logic cal_shadow;
  logic marker_rx_shadow;
  logic [7:0] rdata;

  // Check a requested write against the enable ordering and mode limits.
  function automatic logic write_allowed(input logic [11:0] a,
                                         input logic [7:0] d);
    if (a == LINK_ENABLE_OFS) begin
      return !d[LINK_ENABLE_BIT] || cal_shadow;
    end else if (a == CAL_MARKER_ENABLE_OFS) begin
      return d[CAL_ENABLE_BIT] || !link_shadow;
    end else if (a == OUTPUT_MODE_OFS) begin
      return !link_shadow && !cal_shadow;
    end else if (a == MULTIFRAME_LENGTH_OFS) begin
      return !link_shadow && mf_len_legal(d[4:0]);
    end else if (a == LSB_CONTROL_OUTPUT_OFS) begin
      return !link_shadow &&
        (!d[MARKER_ENABLE_BIT] || marker_rx_shadow);
    end else begin
      return !link_shadow;
    end
  endfunction

  // The legal length table per mode is not known here; only a floor applies.
  function automatic logic mf_len_legal(input logic [4:0] len);
    return len >= MF_LEN_MIN;
  endfunction

  assign pready_out = 1'b1;
  assign apb_access = psel_in && penable_in;
  assign apb_write = apb_access && pwrite_in;

  // A process, not an assign, so that a change of a shadow alone is seen.
  always_comb begin
    cmd_ok = !pwdata_in[CMD_WRITE_BIT] ||
      write_allowed(pwdata_in[CMD_ADDR_LSB +: 12],
                    pwdata_in[CMD_WDATA_LSB +: 8]);
  end

  always_comb begin
    prdata_out = 32'h0000_0000;
    pslverr_out = 1'b0;
    if (paddr_in == CTL_STATUS_OFS) begin
      prdata_out[ST_BUSY_BIT] = state != SLC_IDLE;
      prdata_out[ST_REFUSED_BIT] = refused;
      prdata_out[ST_LINK_BIT] = link_shadow;
      prdata_out[ST_CAL_BIT] = cal_shadow;
      prdata_out[ST_RDATA_LSB +: 8] = rdata;
    end else if (paddr_in == CTL_COMMAND_OFS) begin
      prdata_out = {cmd_write, 7'h00, cmd_wdata, 4'h0, cmd_addr};
    end else begin
      pslverr_out = apb_access;
    end
  end

  // A command is taken only when idle and legal; otherwise it is refused.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= SLC_IDLE;
      cmd_write <= 1'b0;
      cmd_addr <= 12'h000;
      cmd_wdata <= 8'h00;
    end else begin
      case (state)
        SLC_IDLE: begin
          if (apb_write && paddr_in == CTL_COMMAND_OFS && cmd_ok) begin
            cmd_write <= pwdata_in[CMD_WRITE_BIT];
            cmd_addr <= pwdata_in[CMD_ADDR_LSB +: 12];
            cmd_wdata <= pwdata_in[CMD_WDATA_LSB +: 8];
            state <= SLC_WAIT_ACK;
          end
        end
        SLC_WAIT_ACK: begin
          if (cfg.ack) begin
            state <= SLC_DONE;
          end
        end
        default: begin
          state <= SLC_IDLE;
        end
      endcase
    end
  end

  // Refused flag: a new refusal wins over a clear in the same cycle.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      refused <= 1'b0;
    end else if (apb_write && paddr_in == CTL_COMMAND_OFS &&
                 (state != SLC_IDLE || !cmd_ok)) begin
      refused <= 1'b1;
    end else if (apb_write && paddr_in == CTL_STATUS_OFS &&
                 pwdata_in[ST_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  // Shadows follow the device reset values and every completed write.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link_shadow <= LINK_ENABLE_RST[LINK_ENABLE_BIT];
      cal_shadow <= ZERO_RST[CAL_ENABLE_BIT];
      marker_rx_shadow <= ZERO_RST[MARKER_RX_ENABLE_BIT];
      rdata <= 8'h00;
    end else if (state == SLC_WAIT_ACK && cfg.ack) begin
      if (!cmd_write) begin
        rdata <= cfg.rdata;
      end else if (cmd_addr == LINK_ENABLE_OFS) begin
        link_shadow <= cmd_wdata[LINK_ENABLE_BIT];
      end else if (cmd_addr == CAL_MARKER_ENABLE_OFS) begin
        cal_shadow <= cmd_wdata[CAL_ENABLE_BIT];
        marker_rx_shadow <= cmd_wdata[MARKER_RX_ENABLE_BIT];
      end
    end
  end

  assign cfg.req = state == SLC_WAIT_ACK;
  assign cfg.write = cmd_write;
  assign cfg.addr = cmd_addr;
  assign cfg.wdata = cmd_wdata;
endmodule // slc_controller

// ---- rtl/slc_device.sv ----
// Serial link output device: configuration registers and transport path.
//
// How it works
// - Marker enable puts timestamp on sample LSB.
// - Marker beats calibration state for the LSB.
// - Software must also enable the marker receiver.
// - Marker delay equals sample path delay.
// - Control bits field in alignment sequence is zero.
// - Software clears link enable before reconfiguring.
// - Disabled link: reset, serializers off, clocks gated.
// - Disabled link holds multiframe counter in reset.
// - Set calibration enable before link enable.
// - Clear link enable before calibration enable.
// - Output mode is five bits, upper bits reserved.
// - Mode changes only with link and calibration off.
// - Multiframe field is frames minus one, reset 31.
// - Software programs only mode-legal multiframe lengths; controller only checks field >= 3.
// - Multiframe length changes only while link disabled.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module slc_device (
  input wire logic clock_in,
  input wire logic reset_in,
  slc_cfg_if.dev cfg,
  input wire logic [slc_pkg::DATA_W-1:0] sample_in,
  input wire logic sample_valid_in,
  input wire logic timestamp_in,
  input wire logic sysref_in,
  input wire logic cal_state_in,
  output logic [slc_pkg::DATA_W-1:0] lane_data_out,
  output logic lane_valid_out,
  output logic link_reset_out,
  output logic serializer_power_down_out,
  output logic link_clock_enable_out,
  output logic lmfc_boundary_out,
  output logic [slc_pkg::FIELD5_W-1:0] output_mode_out,
  output logic [1:0] ila_control_bits_out,
  output logic cal_enable_out,
  output logic marker_input_receiver_enable_out
);
  import slc_pkg::*;

  logic [7:0] lsb_control_output_reg;
  logic [7:0] link_enable_reg;
  logic [4:0] output_mode_select;
  logic [4:0] frames_per_multiframe_m1;
  logic [7:0] manual_sync_request_reg;
  logic [7:0] link_control_reg;
  logic [7:0] test_pattern_reg;
  logic [7:0] device_id_param_reg;
  logic [7:0] frame_character_reg;
  logic [7:0] channel_power_down_reg;
  logic [7:0] extra_lanes_link_a_reg;
  logic [7:0] extra_lanes_link_b_reg;
  logic [7:0] cal_marker_enable_reg;
  logic link_enable;
  logic cfg_write;
  logic ack;
  logic [7:0] rdata;
  logic ts_sync1;
  logic ts_sync2;
  logic sysref_sync1;
  logic sysref_sync2;
  logic sysref_last;
  logic [4:0] lmfc_count;
  logic [4:0] next_lmfc_count;
  logic [DATA_W-1:0] sample_d1;
  logic [DATA_W-1:0] sample_d2;
  logic [1:0] valid_pipe;
  logic [1:0] cal_pipe;
  logic lsb_bit;

  assign link_enable = link_enable_reg[LINK_ENABLE_BIT];
  assign cfg_write = cfg.req && !ack && cfg.write;

  // Read decode; unmapped offsets read as zero.
  function automatic logic [7:0] read_reg(input logic [11:0] a);
    if (a == LSB_CONTROL_OUTPUT_OFS) begin
      return lsb_control_output_reg;
    end else if (a == LINK_ENABLE_OFS) begin
      return link_enable_reg;
    end else if (a == OUTPUT_MODE_OFS) begin
      return {3'h0, output_mode_select};
    end else if (a == MULTIFRAME_LENGTH_OFS) begin
      return {3'h0, frames_per_multiframe_m1};
    end else if (a == MANUAL_SYNC_REQUEST_OFS) begin
      return manual_sync_request_reg;
    end else if (a == LINK_CONTROL_OFS) begin
      return link_control_reg;
    end else if (a == TEST_PATTERN_OFS) begin
      return test_pattern_reg;
    end else if (a == DEVICE_ID_PARAM_OFS) begin
      return device_id_param_reg;
    end else if (a == FRAME_CHARACTER_OFS) begin
      return frame_character_reg;
    end else if (a == LINK_SYSTEM_STATUS_OFS) begin
      return {3'h0, lmfc_count == 5'h00, link_clock_enable_out,
        cal_marker_enable_reg[MARKER_RX_ENABLE_BIT],
        cal_marker_enable_reg[CAL_ENABLE_BIT], link_enable};
    end else if (a == CHANNEL_POWER_DOWN_OFS) begin
      return channel_power_down_reg;
    end else if (a == EXTRA_LANES_LINK_A_OFS) begin
      return extra_lanes_link_a_reg;
    end else if (a == EXTRA_LANES_LINK_B_OFS) begin
      return extra_lanes_link_b_reg;
    end else if (a == CAL_MARKER_ENABLE_OFS) begin
      return cal_marker_enable_reg;
    end else begin
      return 8'h00;
    end
  endfunction

  // Each request is answered one cycle after it is seen, then ack drops.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ack <= 1'b0;
      rdata <= 8'h00;
    end else begin
      ack <= cfg.req && !ack;
      if (cfg.req && !ack && !cfg.write) begin
        rdata <= read_reg(cfg.addr);
      end
    end
  end

  assign cfg.ack = ack;
  assign cfg.rdata = rdata;

  // Register writes. The device does not police write ordering; it trusts
  // the controller to keep the enable sequence.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lsb_control_output_reg <= LSB_CONTROL_OUTPUT_RST;
      link_enable_reg <= LINK_ENABLE_RST;
      output_mode_select <= OUTPUT_MODE_RST[4:0];
      frames_per_multiframe_m1 <= MULTIFRAME_LENGTH_RST[4:0];
      manual_sync_request_reg <= MANUAL_SYNC_REQUEST_RST;
      link_control_reg <= LINK_CONTROL_RST;
      test_pattern_reg <= ZERO_RST;
      device_id_param_reg <= ZERO_RST;
      frame_character_reg <= ZERO_RST;
      channel_power_down_reg <= ZERO_RST;
      extra_lanes_link_a_reg <= ZERO_RST;
      extra_lanes_link_b_reg <= ZERO_RST;
      cal_marker_enable_reg <= ZERO_RST;
    end else if (cfg_write) begin
      if (cfg.addr == LSB_CONTROL_OUTPUT_OFS) begin
        lsb_control_output_reg <= cfg.wdata;
      end else if (cfg.addr == LINK_ENABLE_OFS) begin
        link_enable_reg <= cfg.wdata;
      end else if (cfg.addr == OUTPUT_MODE_OFS) begin
        output_mode_select <= cfg.wdata[4:0];
      end else if (cfg.addr == MULTIFRAME_LENGTH_OFS) begin
        frames_per_multiframe_m1 <= cfg.wdata[4:0];
      end else if (cfg.addr == MANUAL_SYNC_REQUEST_OFS) begin
        manual_sync_request_reg <= cfg.wdata;
      end else if (cfg.addr == LINK_CONTROL_OFS) begin
        link_control_reg <= cfg.wdata;
      end else if (cfg.addr == TEST_PATTERN_OFS) begin
        test_pattern_reg <= cfg.wdata;
      end else if (cfg.addr == DEVICE_ID_PARAM_OFS) begin
        device_id_param_reg <= cfg.wdata;
      end else if (cfg.addr == FRAME_CHARACTER_OFS) begin
        frame_character_reg <= cfg.wdata;
      end else if (cfg.addr == CHANNEL_POWER_DOWN_OFS) begin
        channel_power_down_reg <= cfg.wdata;
      end else if (cfg.addr == EXTRA_LANES_LINK_A_OFS) begin
        extra_lanes_link_a_reg <= cfg.wdata;
      end else if (cfg.addr == EXTRA_LANES_LINK_B_OFS) begin
        extra_lanes_link_b_reg <= cfg.wdata;
      end else if (cfg.addr == CAL_MARKER_ENABLE_OFS) begin
        cal_marker_enable_reg <= cfg.wdata;
      end
    end
  end

  // Pin synchronisers for the marker and the alignment pulse.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ts_sync1 <= 1'b0;
      ts_sync2 <= 1'b0;
      sysref_sync1 <= 1'b0;
      sysref_sync2 <= 1'b0;
      sysref_last <= 1'b0;
    end else begin
      ts_sync1 <= timestamp_in;
      ts_sync2 <= ts_sync1;
      sysref_sync1 <= sysref_in;
      sysref_sync2 <= sysref_sync1;
      sysref_last <= sysref_sync2;
    end
  end

  // Multiframe counter; held at zero while the link is off so that an
  // alignment pulse arriving then cannot move it.
  always_comb begin
    if (!link_enable) begin
      next_lmfc_count = 5'h00;
    end else if (sysref_sync2 && !sysref_last) begin
      next_lmfc_count = 5'h00;
    end else if (lmfc_count == frames_per_multiframe_m1) begin
      next_lmfc_count = 5'h00;
    end else begin
      next_lmfc_count = lmfc_count + 5'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lmfc_count <= 5'h00;
      lmfc_boundary_out <= 1'b0;
    end else begin
      lmfc_count <= next_lmfc_count;
      lmfc_boundary_out <= link_enable && next_lmfc_count == 5'h00;
    end
  end

  // Samples wait two cycles so that they meet the marker after its
  // synchroniser; both then leave through the same output register.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sample_d1 <= '0;
      sample_d2 <= '0;
      valid_pipe <= 2'h0;
      cal_pipe <= 2'h0;
    end else begin
      sample_d1 <= sample_in;
      sample_d2 <= sample_d1;
      valid_pipe <= {valid_pipe[0], sample_valid_in};
      cal_pipe <= {cal_pipe[0], cal_state_in};
    end
  end

  // A marker reaches the LSB only if its receiver is powered too.
  always_comb begin
    if (lsb_control_output_reg[MARKER_ENABLE_BIT]) begin
      lsb_bit = ts_sync2 &&
        cal_marker_enable_reg[MARKER_RX_ENABLE_BIT];
    end else if (link_control_reg[CAL_STATE_ENABLE_BIT]) begin
      lsb_bit = cal_pipe[1];
    end else begin
      lsb_bit = sample_d2[0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lane_data_out <= '0;
      lane_valid_out <= 1'b0;
    end else if (!link_enable) begin
      lane_data_out <= '0;
      lane_valid_out <= 1'b0;
    end else begin
      lane_data_out <= {sample_d2[DATA_W-1:1], lsb_bit};
      lane_valid_out <= valid_pipe[1];
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link_reset_out <= 1'b1;
      serializer_power_down_out <= 1'b1;
      link_clock_enable_out <= 1'b0;
      ila_control_bits_out <= ILA_CONTROL_BITS;
    end else begin
      link_reset_out <= !link_enable;
      serializer_power_down_out <= !link_enable;
      link_clock_enable_out <= link_enable;
      ila_control_bits_out <= ILA_CONTROL_BITS;
    end
  end

  assign output_mode_out = output_mode_select;
  assign cal_enable_out = cal_marker_enable_reg[CAL_ENABLE_BIT];
  assign marker_input_receiver_enable_out =
    cal_marker_enable_reg[MARKER_RX_ENABLE_BIT];
endmodule // slc_device

// ---- rtl/slc_pkg.sv ----
// Shared constants for the serial link output control block and its controller.
package slc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // Device register offsets.
  localparam logic [11:0] LSB_CONTROL_OUTPUT_OFS = 12'h160;
  localparam logic [11:0] LINK_ENABLE_OFS = 12'h200;
  localparam logic [11:0] OUTPUT_MODE_OFS = 12'h201;
  localparam logic [11:0] MULTIFRAME_LENGTH_OFS = 12'h202;
  localparam logic [11:0] MANUAL_SYNC_REQUEST_OFS = 12'h203;
  localparam logic [11:0] LINK_CONTROL_OFS = 12'h204;
  localparam logic [11:0] TEST_PATTERN_OFS = 12'h205;
  localparam logic [11:0] DEVICE_ID_PARAM_OFS = 12'h206;
  localparam logic [11:0] FRAME_CHARACTER_OFS = 12'h207;
  localparam logic [11:0] LINK_SYSTEM_STATUS_OFS = 12'h208;
  localparam logic [11:0] CHANNEL_POWER_DOWN_OFS = 12'h209;
  localparam logic [11:0] EXTRA_LANES_LINK_A_OFS = 12'h20A;
  localparam logic [11:0] EXTRA_LANES_LINK_B_OFS = 12'h20B;
  localparam logic [11:0] CAL_MARKER_ENABLE_OFS = 12'h0F0;

  // Device reset values.
  localparam logic [7:0] LSB_CONTROL_OUTPUT_RST = 8'h00;
  localparam logic [7:0] LINK_ENABLE_RST = 8'h01;
  localparam logic [7:0] OUTPUT_MODE_RST = 8'h02;
  localparam logic [7:0] MULTIFRAME_LENGTH_RST = 8'h1F;
  localparam logic [7:0] MANUAL_SYNC_REQUEST_RST = 8'h01;
  localparam logic [7:0] LINK_CONTROL_RST = 8'h02;
  localparam logic [7:0] ZERO_RST = 8'h00;

  // Field positions.
  localparam int LINK_ENABLE_BIT = 0;
  localparam int MARKER_ENABLE_BIT = 0;
  localparam int CAL_ENABLE_BIT = 0;
  localparam int MARKER_RX_ENABLE_BIT = 1;
  localparam int FIELD5_W = 5;
  localparam int CAL_STATE_ENABLE_BIT = 2;
  localparam logic [1:0] ILA_CONTROL_BITS = 2'h0;

  // Controller register offsets on APB.
  localparam logic [7:0] CTL_COMMAND_OFS = 8'h00;
  localparam logic [7:0] CTL_STATUS_OFS = 8'h04;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_WDATA_LSB = 16;
  localparam int CMD_WRITE_BIT = 31;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_LINK_BIT = 2;
  localparam int ST_CAL_BIT = 3;
  localparam int ST_RDATA_LSB = 8;
  localparam logic [4:0] MF_LEN_MIN = 5'h03;

  typedef enum logic [1:0] {
    SLC_IDLE,
    SLC_WAIT_ACK,
    SLC_DONE
  } slc_ctl_state_e;
endpackage : slc_pkg

// ---- test/serial_link_output_control_tb_top.sv ----
// Self-checking bench for the controller and device joined by their link.
`timescale 1ns/1ps
module serial_link_output_control_tb_top;
  import slc_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [31:0] seed = 32'h000017F4;
  logic [7:0] sample_in = 8'h00, lane_data_out;
  logic sample_valid_in = 1'b0, timestamp_in = 1'b0, sysref_in = 1'b0;
  logic cal_state_in = 1'b0, lane_valid_out, link_reset_out;
  logic serializer_power_down_out, link_clock_enable_out;
  logic lmfc_boundary_out, cal_enable_out, marker_input_receiver_enable_out;
  logic [4:0] output_mode_out;
  logic [1:0] ila_control_bits_out;
  int n_errors = 0;
  int checks_done = 0;

  slc_cfg_if u_slc_cfg_if ();
  slc_controller u_slc_controller (.clock_in, .reset_in,
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .cfg(u_slc_cfg_if));
  slc_device u_slc_device (.clock_in, .reset_in, .cfg(u_slc_cfg_if),
    .sample_in, .sample_valid_in, .timestamp_in, .sysref_in,
    .cal_state_in, .lane_data_out, .lane_valid_out, .link_reset_out,
    .serializer_power_down_out, .link_clock_enable_out,
    .lmfc_boundary_out, .output_mode_out, .ila_control_bits_out,
    .cal_enable_out, .marker_input_receiver_enable_out);
  slc_link_checker u_slc_link_checker (.clock_in, .reset_in,
    .req(u_slc_cfg_if.req), .ack(u_slc_cfg_if.ack), .lane_valid_out,
    .link_reset_out, .serializer_power_down_out, .link_clock_enable_out,
    .lmfc_boundary_out, .output_mode_out, .ila_control_bits_out,
    .cal_enable_out);

  initial begin
    forever #20 clock_in = ~clock_in;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic timed_out();
    n_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask

  // One APB transfer; data is taken at the edge that sees pready high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int i;
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_in);
      if (pready === 1'b1) break;
    end
    if (i == 20) timed_out();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Issues one device access and polls until the controller is idle.
  task automatic dev(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, input logic refuse,
                     output logic [7:0] q);
    logic [31:0] s;
    logic e;
    int i;
    apb(1'b1, CTL_COMMAND_OFS, {wr, 7'h00, d, 4'h0, a}, s, e);
    for (i = 0; i < 20; i++) begin
      apb(1'b0, CTL_STATUS_OFS, 32'h0, s, e);
      if (s[ST_BUSY_BIT] === 1'b0) break;
    end
    if (i == 20) timed_out();
    check(s[ST_REFUSED_BIT], refuse, "refusal");
    if (s[ST_REFUSED_BIT] === 1'b1) apb(1'b1, CTL_STATUS_OFS, 32'h2, s, e);
    q = s[15:8];
  endtask

  initial begin
    logic [7:0] q;
    logic [31:0] s, r;
    logic e;
    logic [8:0] hist [8];
    logic [7:0] rst_v [5] = '{LINK_ENABLE_RST, OUTPUT_MODE_RST,
      MULTIFRAME_LENGTH_RST, MANUAL_SYNC_REQUEST_RST, LINK_CONTROL_RST};
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      dev(1'b0, 12'(LINK_ENABLE_OFS + k), 8'h00, 1'b0, q);
      check(q, rst_v[k], "reset value");
    end
    apb(1'b0, 8'h08, 32'h0, s, e);
    check(s, 32'h0, "unmapped apb data");
    check(e, 1'b1, "unmapped apb error");
    dev(1'b0, 12'h3FF, 8'h00, 1'b0, q);
    check(q, 8'h00, "unmapped device");
    $display("test reset values done");

    // Link starts enabled, so the guarded fields must be refused first.
    dev(1'b1, OUTPUT_MODE_OFS, 8'h05, 1'b1, q);
    dev(1'b1, MULTIFRAME_LENGTH_OFS, 8'h07, 1'b1, q);
    dev(1'b1, LINK_ENABLE_OFS, 8'h00, 1'b0, q);
    repeat (3) @(posedge clock_in);
    #1;
    check({link_reset_out, serializer_power_down_out,
      link_clock_enable_out}, 3'b110, "link off");
    dev(1'b1, OUTPUT_MODE_OFS, 8'hFF, 1'b0, q);
    dev(1'b0, OUTPUT_MODE_OFS, 8'h00, 1'b0, q);
    check({q, output_mode_out}, {8'h1F, 5'h1F}, "mode field");
    dev(1'b1, MULTIFRAME_LENGTH_OFS, 8'h02, 1'b1, q);
    dev(1'b1, MULTIFRAME_LENGTH_OFS, 8'hE3, 1'b0, q);
    dev(1'b0, MULTIFRAME_LENGTH_OFS, 8'h00, 1'b0, q);
    check(q, 8'h03, "multiframe field");
    dev(1'b1, LINK_ENABLE_OFS, 8'h01, 1'b1, q);
    dev(1'b1, CAL_MARKER_ENABLE_OFS, 8'h03, 1'b0, q);
    dev(1'b1, LINK_ENABLE_OFS, 8'h01, 1'b0, q);
    dev(1'b1, CAL_MARKER_ENABLE_OFS, 8'h02, 1'b1, q);
    dev(1'b0, LINK_SYSTEM_STATUS_OFS, 8'h00, 1'b0, q);
    check(q[2:0], 3'b111, "system status");
    check({cal_enable_out, marker_input_receiver_enable_out}, 2'b11,
      "enable outputs");
    $display("test ordering done");

    cal_state_in <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      dev(1'b1, LINK_ENABLE_OFS, 8'h00, 1'b0, q);
      dev(1'b1, LSB_CONTROL_OUTPUT_OFS, {7'h00, m == 0}, 1'b0, q);
      dev(1'b1, LINK_CONTROL_OFS, m < 2 ? 8'h06 : 8'h02, 1'b0, q);
      dev(1'b1, LINK_ENABLE_OFS, 8'h01, 1'b0, q);
      for (int i = 0; i < 40; i++) begin
        @(posedge clock_in);
        r = xs();
        sample_in <= r[7:0];
        timestamp_in <= r[8];
        sysref_in <= r[10];
        sample_valid_in <= r[9];
        hist[i % 8] = {r[9], r[7:1], m == 0 ? r[8] : m == 1 ? 1'b1 : r[0]};
        #1;
        if (i >= 4) check({lane_valid_out, lane_data_out},
          hist[(i - 3) % 8], "lane word");
      end
      $display("test lane pass %0d done", m);
    end

    // Length field holds 3, so a quiet alignment pin gives a pulse every 4.
    sysref_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    s = 32'h0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clock_in);
      #1;
      s += lmfc_boundary_out;
    end
    check(s, 32'h4, "multiframe period");
    $display("test multiframe period done");

    dev(1'b1, LINK_ENABLE_OFS, 8'h00, 1'b0, q);
    for (int i = 0; i < 12; i++) begin
      @(posedge clock_in);
      sysref_in <= ~sysref_in;
      #1;
      if (i > 4) check({lmfc_boundary_out, lane_valid_out, lane_data_out},
        10'h000, "disabled lane");
    end
    $display("test disabled link done");

    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    dev(1'b0, MULTIFRAME_LENGTH_OFS, 8'h00, 1'b0, q);
    check(q, 8'h1F, "multiframe after reset");
    $display("test second reset done");
    give_verdict();
  end
endmodule // serial_link_output_control_tb_top

// ---- test/slc_link_asserts.sv ----
// Concurrent checks on the configuration link and the device outputs.
`timescale 1ns/1ps
module slc_link_checker (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic req,
  input wire logic ack,
  input wire logic lane_valid_out,
  input wire logic link_reset_out,
  input wire logic serializer_power_down_out,
  input wire logic link_clock_enable_out,
  input wire logic lmfc_boundary_out,
  input wire logic [4:0] output_mode_out,
  input wire logic [1:0] ila_control_bits_out,
  input wire logic cal_enable_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  chk_ack_single: assert property (ack |=> !ack)
    else $error("acknowledge lasted more than one cycle");
  chk_ack_prompt: assert property (req && !ack |=> ack)
    else $error("acknowledge did not follow the request");
  chk_ack_cause: assert property ($rose(ack) |-> $past(req))
    else $error("acknowledge without a request");
  chk_req_release: assert property (ack |=> !req)
    else $error("request held after acknowledge");
  chk_ila_zero: assert property (ila_control_bits_out == 2'h0)
    else $error("alignment control bit count not zero");
  chk_off_gated: assert property (
    !link_clock_enable_out [*2] |-> link_reset_out &&
    serializer_power_down_out)
    else $error("disabled link not in reset or powered");
  chk_off_quiet: assert property (
    link_reset_out [*3] |-> !lane_valid_out && !lmfc_boundary_out)
    else $error("disabled link still active");
  chk_mode_frozen: assert property (
    (cal_enable_out || link_clock_enable_out) |=> $stable(output_mode_out))
    else $error("mode changed while link or calibration on");

  cover property (ack);
  cover property ($rose(link_clock_enable_out));
  cover property (lmfc_boundary_out);
endmodule // slc_link_checker
